// ===== src/iopc_cfg.svh
`ifndef IOPC_CFG_SVH
`define IOPC_CFG_SVH

// ********************************************************************
// object indices
// ********************************************************************
`define IOPC_IDX_DEVTYPE 16'h1000
`define IOPC_IDX_IDENT 16'h1018
`define IOPC_IDX_CH_HI 8'h80
`define IOPC_NUM_CH 4

// ********************************************************************
// per-channel subindices
// ********************************************************************
`define IOPC_SUB_COUNT 8'h00
`define IOPC_SUB_MCT 8'h22
`define IOPC_SUB_OFFS 8'h23
`define IOPC_SUB_PDIN 8'h24
`define IOPC_SUB_PDOUT 8'h25
`define IOPC_SUB_COMPAT 8'h26
`define IOPC_SUB_SPARE 8'h27
`define IOPC_SUB_MCTL 8'h28
`define IOPC_CH_MAX_SUB 8'h28

// ********************************************************************
// identity subindices and fixed values
// ********************************************************************
`define IOPC_SUB_VENDOR 8'h01
`define IOPC_SUB_PRODUCT 8'h02
`define IOPC_SUB_REVISION 8'h03
`define IOPC_SUB_SERIAL 8'h04
`define IOPC_IDENT_COUNT 8'h04
`define IOPC_COE_PROFILE 16'h1389

// ********************************************************************
// reset values
// ********************************************************************
`define IOPC_RST_8 8'h00
`define IOPC_RST_16 16'h0000

// ********************************************************************
// field positions
// ********************************************************************
`define IOPC_MCT_BASE_HI 7
`define IOPC_MCT_BASE_LO 6
`define IOPC_MCT_MUL_HI 5
`define IOPC_PD_BYTE_BIT 7
`define IOPC_PD_SIO_BIT 6
`define IOPC_PD_LEN_HI 4
`define IOPC_MCTL_MODE_HI 3
`define IOPC_MCTL_DS_LO 4
`define IOPC_DS_ACTIVE 12'h002
`define IOPC_DS_UPLOAD_OFF 12'h004

// ********************************************************************
// minimum cycle time decode, in units of 0.1 ms
// ********************************************************************
`define IOPC_MCT_UNIT_US 100
`define IOPC_MCT_OFS1 13'h0040
`define IOPC_MCT_OFS2 13'h0140
`define IOPC_MCT_OFS3 13'h0540
`define IOPC_MCT_SH1 2
`define IOPC_MCT_SH2 4
`define IOPC_MCT_SH3 6

`endif

// ===== src/iopc_pkg.sv
`default_nettype none
package iopc_pkg;

   typedef enum logic [3:0] {
      IOPC_MODE_INACTIVE = 4'h0,
      IOPC_MODE_DIN = 4'h1,
      IOPC_MODE_DOUT = 4'h2,
      IOPC_MODE_CYCLIC = 4'h3,
      IOPC_MODE_HALTED = 4'h4
   } iopc_mode_e;

   typedef logic [12:0] iopc_mct_t;
   typedef logic [8:0] iopc_pdlen_t;

endpackage

`default_nettype wire

// ===== src/iopc_top.sv
// Notes on behaviour
// - time base 00: multiplier x 0.1 ms; 01: 6.4 ms plus multiplier x 0.4 ms.
// - time base 10 is 32.0 ms plus multiplier x 1.6 ms.
// - time base 11 is 134.4 ms plus multiplier x 6.4 ms.
// - length bits 4..0; bit 7 clear means bits, set means bytes minus one.
// - length byte bit 6 set flags a device able to run standard digital I/O.
// - each channel keeps its own input and output length bytes, zero after reset.
// - control bits 3..0: 0 off, 1 digital in, 2 digital out, 3 cyclic.
// - mode 4 runs the protocol halted, data exchanged only on demand.
// - control bits 15..4: 2 enables data storage, 4 disables upload; reset zero.
// - device type reads profile 5001 low, modular profile value high, read only.
// - revision word reads variant number low, description revision high, read only.
// - serial reads year in 7..0, week in 15..8, zero above, read only.
// - identity count entry reads 4, followed by four 32-bit entries.
// - cycle time byte: bits 7..6 time base, bits 5..0 multiplier.
// - four channel groups, channel n at index group n for n 0..3.
`timescale 1ns/100ps
`default_nettype none
`include "iopc_cfg.svh"

module iopc_top #(
   parameter logic [15:0] MDP_PROFILE = 16'h0001, // arbitrary value
   parameter logic [31:0] VENDOR_CODE = 32'h0000_0a5a, // arbitrary value
   parameter logic [31:0] PART_CODE = 32'h0000_1234, // arbitrary value
   parameter logic [15:0] VARIANT_NUM = 16'h0000, // arbitrary value
   parameter logic [15:0] DESC_REV = 16'h0001, // arbitrary value
   parameter logic [7:0] PROD_YEAR = 8'h00,
   parameter logic [7:0] PROD_WEEK = 8'h00
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [15:0] index_i,
   input wire logic [7:0] subidx_i,
   input wire logic [31:0] wdata_i,
   output logic ack_o,
   output logic err_o,
   output logic [31:0] rdata_o,
   output logic [3:0][12:0] min_cycle_o,
   output logic [3:0][8:0] pd_in_bits_o,
   output logic [3:0][8:0] pd_out_bits_o,
   output logic [3:0] in_standard_io_capable_o,
   output logic [3:0] out_standard_io_capable_o,
   output logic [3:0][3:0] port_mode_o,
   output logic [3:0] port_din_o,
   output logic [3:0] port_dout_o,
   output logic [3:0] port_cyclic_o,
   output logic [3:0] comm_halted_state_o,
   output logic [3:0] ds_active_o,
   output logic [3:0] ds_upload_off_o
);

   // ********************************************************************
   // helpers
   // ********************************************************************
   function automatic iopc_pkg::iopc_mct_t mct_decode(input logic [7:0] b);
      iopc_pkg::iopc_mct_t m;
      m = {7'h00, b[`IOPC_MCT_MUL_HI:0]};
      case (b[`IOPC_MCT_BASE_HI:`IOPC_MCT_BASE_LO])
         2'b00: mct_decode = m;
         2'b01: mct_decode = 13'(`IOPC_MCT_OFS1 + (m << `IOPC_MCT_SH1));
         2'b10: mct_decode = 13'(`IOPC_MCT_OFS2 + (m << `IOPC_MCT_SH2));
         default: mct_decode = 13'(`IOPC_MCT_OFS3 + (m << `IOPC_MCT_SH3));
      endcase
   endfunction

   function automatic iopc_pkg::iopc_pdlen_t pd_bits(input logic [7:0] b);
      iopc_pkg::iopc_pdlen_t l;
      l = {4'h0, b[`IOPC_PD_LEN_HI:0]};
      if (b[`IOPC_PD_BYTE_BIT]) begin
         pd_bits = 9'((l + 9'h001) << 3);
      end else begin
         pd_bits = l;
      end
   endfunction

   // ********************************************************************
   // channel storage
   // ********************************************************************
   logic [7:0] mct [0:3];
   logic [7:0] offs [0:3];
   logic [7:0] pdin [0:3];
   logic [7:0] pdout [0:3];
   logic [15:0] compat [0:3];
   logic [15:0] spare [0:3];
   logic [15:0] mctl [0:3];

   logic ch_hit;
   logic [1:0] ch;
   logic ch_sub_ok;
   logic ch_sub_rw;

   // index group n selects channel n
   assign ch_hit = (index_i[15:8] == `IOPC_IDX_CH_HI) && (index_i[3:0] == 4'h0)
                   && (index_i[7:6] == 2'b00);
   assign ch = index_i[5:4];
   assign ch_sub_rw = (subidx_i >= `IOPC_SUB_MCT) && (subidx_i <= `IOPC_CH_MAX_SUB);
   assign ch_sub_ok = ch_sub_rw || (subidx_i == `IOPC_SUB_COUNT);

   // ********************************************************************
   // writes
   // ********************************************************************
   logic ch_wr;

   // one block per object; a refused write falls through every enable
   assign ch_wr = req_i && wr_i && ch_hit;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            mct[c] <= `IOPC_RST_8;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_MCT) begin
         mct[ch] <= wdata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            offs[c] <= `IOPC_RST_8;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_OFFS) begin
         offs[ch] <= wdata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            pdin[c] <= `IOPC_RST_8;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_PDIN) begin
         pdin[ch] <= wdata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            pdout[c] <= `IOPC_RST_8;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_PDOUT) begin
         pdout[ch] <= wdata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            compat[c] <= `IOPC_RST_16;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_COMPAT) begin
         compat[ch] <= wdata_i[15:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            spare[c] <= `IOPC_RST_16;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_SPARE) begin
         spare[ch] <= wdata_i[15:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            mctl[c] <= `IOPC_RST_16;
         end
      end else if (ch_wr && subidx_i == `IOPC_SUB_MCTL) begin
         mctl[ch] <= wdata_i[15:0];
      end
   end

   // ********************************************************************
   // object read and answer
   // ********************************************************************
   logic [31:0] next_rdata;
   logic next_err;

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (ch_hit && ch_sub_ok) begin
         case (subidx_i)
            `IOPC_SUB_COUNT: next_rdata = {24'h00_0000, `IOPC_CH_MAX_SUB};
            `IOPC_SUB_MCT: next_rdata = {24'h00_0000, mct[ch]};
            `IOPC_SUB_OFFS: next_rdata = {24'h00_0000, offs[ch]};
            `IOPC_SUB_PDIN: next_rdata = {24'h00_0000, pdin[ch]};
            `IOPC_SUB_PDOUT: next_rdata = {24'h00_0000, pdout[ch]};
            `IOPC_SUB_COMPAT: next_rdata = {16'h0000, compat[ch]};
            `IOPC_SUB_SPARE: next_rdata = {16'h0000, spare[ch]};
            default: next_rdata = {16'h0000, mctl[ch]};
         endcase
         // the count entry is fixed; writing it is refused
         next_err = wr_i && !ch_sub_rw;
      end else if (index_i == `IOPC_IDX_DEVTYPE && subidx_i == `IOPC_SUB_COUNT) begin
         next_rdata = {MDP_PROFILE, `IOPC_COE_PROFILE};
         next_err = wr_i;
      end else if (index_i == `IOPC_IDX_IDENT && subidx_i <= `IOPC_SUB_SERIAL) begin
         case (subidx_i)
            `IOPC_SUB_COUNT: next_rdata = {24'h00_0000, `IOPC_IDENT_COUNT};
            `IOPC_SUB_VENDOR: next_rdata = VENDOR_CODE;
            `IOPC_SUB_PRODUCT: next_rdata = PART_CODE;
            `IOPC_SUB_REVISION: next_rdata = {DESC_REV, VARIANT_NUM};
            default: next_rdata = {16'h0000, PROD_WEEK, PROD_YEAR};
         endcase
         next_err = wr_i;
      end else begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end else begin
         ack_o <= req_i;
         err_o <= req_i && next_err;
         // write answers carry no data
         rdata_o <= (req_i && !wr_i && !next_err) ? next_rdata : 32'h0000_0000;
      end
   end

   // ********************************************************************
   // decoded port settings
   // ********************************************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         min_cycle_o <= '0;
      end else begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            min_cycle_o[c] <= mct_decode(mct[c]);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pd_in_bits_o <= '0;
         pd_out_bits_o <= '0;
      end else begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            pd_in_bits_o[c] <= pd_bits(pdin[c]);
            pd_out_bits_o[c] <= pd_bits(pdout[c]);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_standard_io_capable_o <= 4'h0;
         out_standard_io_capable_o <= 4'h0;
      end else begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            in_standard_io_capable_o[c] <= pdin[c][`IOPC_PD_SIO_BIT];
            out_standard_io_capable_o[c] <= pdout[c][`IOPC_PD_SIO_BIT];
         end
      end
   end

   // ********************************************************************
   // mode and data storage flags
   // ********************************************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         port_mode_o <= '0;
         port_din_o <= 4'h0;
         port_dout_o <= 4'h0;
         port_cyclic_o <= 4'h0;
         comm_halted_state_o <= 4'h0;
      end else begin
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            port_mode_o[c] <= mctl[c][`IOPC_MCTL_MODE_HI:0];
            // unknown mode codes leave every mode flag low, i.e. port off
            port_din_o[c] <= mctl[c][3:0] == iopc_pkg::IOPC_MODE_DIN;
            port_dout_o[c] <= mctl[c][3:0] == iopc_pkg::IOPC_MODE_DOUT;
            port_cyclic_o[c] <= mctl[c][3:0] == iopc_pkg::IOPC_MODE_CYCLIC;
            comm_halted_state_o[c] <= mctl[c][3:0] == iopc_pkg::IOPC_MODE_HALTED;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ds_active_o <= 4'h0;
         ds_upload_off_o <= 4'h0;
      end else begin
         // exact codes only; a mixed word raises neither flag
         for (int c = 0; c < `IOPC_NUM_CH; c++) begin
            ds_active_o[c] <= mctl[c][15:`IOPC_MCTL_DS_LO] == `IOPC_DS_ACTIVE;
            ds_upload_off_o[c] <= mctl[c][15:`IOPC_MCTL_DS_LO] == `IOPC_DS_UPLOAD_OFF;
         end
      end
   end

endmodule

`default_nettype wire

// ===== testbench/iopc_tb_pkg.sv
`default_nettype none
package iopc_tb_pkg;
   // expected cycle time in 0.1 ms steps
   function automatic logic [12:0] mct(input logic [7:0] b);
      logic [12:0] m;
      m = {7'h0, b[5:0]};
      case (b[7:6])
         2'b00: return m;
         2'b01: return 13'h0040 + (m << 2);
         2'b10: return 13'h0140 + (m << 4);
         default: return 13'h0540 + (m << 6);
      endcase
   endfunction
   // bit count of a length byte
   function automatic logic [8:0] pdx(input logic [7:0] b);
      return b[7] ? ({4'h0, b[4:0]} + 9'h001) << 3 : {4'h0, b[4:0]};
   endfunction
endpackage
`default_nettype wire

// ===== testbench/iopc_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module iopc_dev_model (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [3:0] cyclic_i,
   input wire logic [3:0] halted_i,
   input wire logic demand_i,
   output logic [3:0] xfer_o
);
   // a halted port only moves data when asked
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         xfer_o <= 4'h0;
      else
         xfer_o <= cyclic_i | (halted_i & {4{demand_i}});
   end
endmodule
`default_nettype wire

// ===== testbench/iopc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module iopc_checker (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [15:0] index_i,
   input wire logic [7:0] subidx_i,
   input wire logic [31:0] wdata_i,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic [31:0] rdata_o,
   input wire logic [3:0][12:0] min_cycle_o,
   input wire logic [3:0][8:0] pd_in_bits_o,
   input wire logic [3:0][3:0] port_mode_o,
   input wire logic [3:0] comm_halted_state_o
);
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   // channel 0 stands for all four; the bench sweeps the others
   wire logic w0 = req_i && wr_i && index_i == 16'h8000;
   wire logic rdq = req_i && !wr_i;
   wire logic [7:0] wb = wdata_i[7:0];
   ack_one_a: assert property (req_i |=> ack_o)
      else $error("request not answered");
   ack_spur_a: assert property (!req_i |=> !ack_o && !err_o)
      else $error("answer without request");
   ident_count_a:
   assert property (rdq && index_i == 16'h1018 && subidx_i == 8'h00 |=> rdata_o == 32'h4)
      else $error("identity count wrong");
   dev_profile_a:
   assert property (rdq && index_i == 16'h1000 && subidx_i == 8'h00
      |=> rdata_o[15:0] == 16'h1389 && !err_o) else $error("device type profile wrong");
   ro_write_a:
   assert property (req_i && wr_i && index_i[15:8] == 8'h10 |=> err_o && rdata_o == 32'h0)
      else $error("read-only write accepted");
   cycle_decode_a:
   assert property (w0 && subidx_i == 8'h22 |=> ##1 min_cycle_o[0] == iopc_tb_pkg::mct($past(wb, 2)))
      else $error("cycle time decode wrong");
   pd_len_a:
   assert property (w0 && subidx_i == 8'h24 |=> ##1 pd_in_bits_o[0] == iopc_tb_pkg::pdx($past(wb, 2)))
      else $error("length decode wrong");
   halt_mode_a:
   assert property (w0 && subidx_i == 8'h28 |=> ##1 port_mode_o[0] == $past(wb, 2) % 16
      && comm_halted_state_o[0] == ($past(wb, 2) % 16 == 4)) else $error("mode decode wrong");
endmodule
bind iopc_top iopc_checker u_iopc_checker (.mclk_i, .rstn_i, .req_i, .wr_i, .index_i,
   .subidx_i, .wdata_i, .ack_o, .err_o, .rdata_o, .min_cycle_o, .pd_in_bits_o, .port_mode_o,
   .comm_halted_state_o);
`default_nettype wire

// ===== testbench/io_port_config_objects_tb.sv
`timescale 1ns/100ps
`default_nettype none
module io_port_config_objects_tb;
   typedef struct packed {logic w; logic [15:0] ix; logic [7:0] sx;
      logic [31:0] wd; logic e; logic [31:0] r;} iopc_row_s;
   logic mclk_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, wr_i = 1'b0, dm = 1'b0, ack_o, err_o, er;
   logic [15:0] index_i = 16'h0;
   logic [7:0] subidx_i = 8'h0, b;
   logic [31:0] wdata_i = 32'h0, rdata_o, rd;
   logic [3:0][12:0] min_cycle_o;
   logic [3:0][8:0] pd_in_bits_o, pd_out_bits_o;
   logic [3:0][3:0] port_mode_o;
   logic [3:0] in_standard_io_capable_o, out_standard_io_capable_o, port_din_o, port_dout_o;
   logic [3:0] port_cyclic_o, comm_halted_state_o, ds_active_o, ds_upload_off_o, xf;
   logic [7:0] pdb [6] = '{8'h00, 8'h1f, 8'h80, 8'h9f, 8'h45, 8'hc2};
   int miscompares = 0, samples_checked = 0, c;
   iopc_row_s rows [17] = '{
      '{1'b0,16'h8000,8'h28,32'h0,1'b0,32'h0}, '{1'b0,16'h1018,8'h00,32'h0,1'b0,32'h4},
      '{1'b0,16'h1000,8'h00,32'h0,1'b0,32'h0005_1389}, '{1'b0,16'h1018,8'h01,32'h0,1'b0,32'hc3c},
      '{1'b0,16'h1018,8'h02,32'h0,1'b0,32'h777}, '{1'b0,16'h1018,8'h03,32'h0,1'b0,32'h6_0000},
      '{1'b0,16'h1018,8'h04,32'h0,1'b0,32'h2a00}, '{1'b1,16'h1000,8'h00,32'h1,1'b1,32'h0},
      '{1'b1,16'h1018,8'h04,32'h1,1'b1,32'h0}, '{1'b0,16'h1018,8'h04,32'h0,1'b0,32'h2a00},
      '{1'b1,16'h8030,8'h27,32'h1234_beef,1'b0,32'h0}, '{1'b0,16'h8030,8'h27,32'h0,1'b0,32'hbeef},
      '{1'b1,16'h8020,8'h23,32'hffff_ffa5,1'b0,32'h0}, '{1'b0,16'h8020,8'h23,32'h0,1'b0,32'ha5},
      '{1'b0,16'h8040,8'h22,32'h0,1'b1,32'h0}, '{1'b1,16'h8010,8'h00,32'h1,1'b1,32'h0},
      '{1'b0,16'h8010,8'h00,32'h0,1'b0,32'h28}};
   // arbitrary identity values; variant number and year stay at their zero defaults
   iopc_top #(.MDP_PROFILE(16'h0005), .VENDOR_CODE(32'h0c3c), .PART_CODE(32'h0777),
      .DESC_REV(16'h0006), .PROD_WEEK(8'h2a))
   u_iopc_top (.mclk_i, .rstn_i, .req_i, .wr_i, .index_i, .subidx_i, .wdata_i, .ack_o, .err_o,
      .rdata_o, .min_cycle_o, .pd_in_bits_o, .pd_out_bits_o, .in_standard_io_capable_o,
      .out_standard_io_capable_o, .port_mode_o, .port_din_o, .port_dout_o, .port_cyclic_o,
      .comm_halted_state_o, .ds_active_o, .ds_upload_off_o);
   iopc_dev_model u_iopc_dev_model (.mclk_i, .rstn_i, .cyclic_i(port_cyclic_o),
      .halted_i(comm_halted_state_o), .demand_i(dm), .xfer_o(xf));
   always #5 mclk_i = ~mclk_i;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one access, then an idle cycle so the driver never flips req twice at one edge
   task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sx,
      input logic [31:0] wd);
      {req_i, wr_i, index_i, subidx_i, wdata_i} = {1'b1, w, ix, sx, wd};
      @(negedge mclk_i);
      req_i = 1'b0;
      {er, rd} = {err_o, rdata_o};
      chk("ack", {31'h0, ack_o}, 32'h1);
      @(negedge mclk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge mclk_i);
      rstn_i = 1'b1;
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].ix, rows[i].sx, rows[i].wd);
         chk("err", {31'h0, er}, {31'h0, rows[i].e});
         chk("rdata", rd, rows[i].r);
      end
      $display("object table done");
      for (int i = 0; i < 16; i++) begin
         c = i % 4;
         b = {2'(i / 4), 6'(c * 21)};
         acc(1'b1, 16'h8000 + 16'(c * 16), 8'h22, {24'h0, b});
         chk("min_cycle", min_cycle_o[c], iopc_tb_pkg::mct(b));
      end
      $display("cycle time done");
      for (int i = 0; i < 6; i++) begin
         {c, b} = {i % 4, pdb[i]};
         acc(1'b1, 16'h8000 + 16'(c * 16), 8'h24, {24'hffffff, b});
         acc(1'b1, 16'h8000 + 16'(c * 16), 8'h25, {24'h0, ~b});
         chk("pd_in", pd_in_bits_o[c], iopc_tb_pkg::pdx(b));
         chk("pd_out", pd_out_bits_o[c], iopc_tb_pkg::pdx(~b));
         chk("sio", {in_standard_io_capable_o[c], out_standard_io_capable_o[c]},
            {b[6], !b[6]});
      end
      $display("length done");
      dm = 1'b1;
      for (int m = 0; m < 6; m++) begin
         c = m % 4;
         acc(1'b1, 16'h8000 + 16'(c * 16), 8'h28, {16'h0, m[0] ? 12'h004 : 12'h002, 4'(m)});
         @(negedge mclk_i);
         chk("mode", port_mode_o[c], 32'(m));
         chk("flags", {port_din_o[c], port_dout_o[c], port_cyclic_o[c],
            comm_halted_state_o[c]}, {m == 1, m == 2, m == 3, m == 4});
         chk("ds", {ds_active_o[c], ds_upload_off_o[c]}, {!m[0], m[0]});
         chk("xfer", xf[c], m == 3 || m == 4);
      end
      dm = 1'b0;
      @(negedge mclk_i);
      chk("xfer", xf[0], 32'h0);
      $display("mode done");
      rstn_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      rstn_i = 1'b1;
      chk("mode", port_mode_o, 32'h0);
      chk("min_cycle", min_cycle_o[3], 32'h0);
      chk("pd_len", {pd_in_bits_o[0], pd_out_bits_o[1]}, 32'h0);
      acc(1'b0, 16'h8030, 8'h27, 32'h0);
      chk("spare", rd, 32'h0);
      $display("reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
